//--- flash_memory_controller_tb.sv
// flash_memory_controller_tb: host and device joined by the link, driven at the software port.
// assumes the host command map of fmc_pkg and a 50 MHz mclk.
`timescale 1ns/1ns
module flash_memory_controller_tb;
    import fmc_pkg::*;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic ext_clk_pin = 1'h0;
    logic [7:0] sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'h0;
    logic sw_rd = 1'h0;
    logic [31:0] sw_rdata;
    logic debug_port_on;
    logic [31:0] rd;
    logic [31:0] st;
    logic [15:0] crc;
    int fail_count = 0;
    int checked = 0;
    int wcnt = 0;
    int w0 = 0;
    fmc_link_if link ();
    fmc_host i_fmc_host (.mclk(mclk), .rst(rst), .ce(1'h1), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link.host));
    fmc_device i_fmc_device (.mclk(mclk), .rst(rst), .ce(1'h1), .link(link.dev),
        .ext_clk_pin(ext_clk_pin), .debug_port_on(debug_port_on));
    fmc_link_properties i_fmc_link_properties (.mclk(mclk), .rst(rst), .req(link.req),
        .we(link.we), .size(link.size), .addr(link.addr), .wdata(link.wdata),
        .ack(link.ack), .err(link.err), .rdata(link.rdata));
    always #10 mclk = ~mclk;
    always @(posedge mclk) if (link.req && !link.ack) wcnt <= wcnt + 1;
    task automatic report_and_stop();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic hang();
        $display("[FAIL] %0t wait ran out", $time);
        fail_count++;
        report_and_stop();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one strobe on the software port; read data land in rd
    task automatic sw(input logic [7:0] a, input logic [31:0] d, input logic rdn);
        @(posedge mclk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= !rdn;
        sw_rd <= rdn;
        @(posedge mclk);
        sw_wr <= 1'h0;
        sw_rd <= 1'h0;
        #1 rd = sw_rdata;
    endtask
    // one link transfer, polled to completion; status in st, data in rd
    task automatic op(input logic [31:0] a, input logic [31:0] d, input logic wr,
        input logic [1:0] sz);
        w0 = wcnt;
        sw(H_ADDR, a, 1'h0);
        sw(H_WDATA, d, 1'h0);
        sw(H_CMD, {28'h0, sz, wr, 1'h1}, 1'h0);
        rd = 32'h1;
        for (int i = 0; i < 40 && rd[0] !== 1'h0; i++) sw(H_STATUS, 32'h0, 1'h1);
        if (rd[0] !== 1'h0) hang();
        st = rd;
        sw(H_RDATA, 32'h0, 1'h1);
    endtask
    task automatic w(input logic [31:0] a, input logic [31:0] d);
        op(a, d, 1'h1, SZ_WORD);
    endtask
    task automatic r(input logic [31:0] a, input logic [31:0] exp);
        op(a, 32'h0, 1'h0, SZ_WORD);
        chk(rd, exp);
    endtask
    task automatic rb(input int b, input logic e);
        op(ADDR_MODE, 32'h0, 1'h0, SZ_WORD);
        chk(32'(rd[b]), 32'(e));
    endtask
    task automatic idle();
        rd = 32'h0;
        for (int i = 0; i < 30 && rd[MR_IDLE] !== 1'h1; i++) op(ADDR_MODE, 32'h0, 1'h0, SZ_WORD);
        if (rd[MR_IDLE] !== 1'h1) hang();
    endtask
    // all-ones data: lane choice cannot matter, only the bit count
    function automatic logic [15:0] crc_ones(input logic [15:0] c, input int n);
        for (int i = 0; i < n; i++) c = {c[14:0], 1'h0} ^ (c[15] ? 16'h0 : CRC_POLY);
        return c;
    endfunction
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        chk(32'(debug_port_on), 32'h1);
        r(ADDR_CRC, 32'h0000_ffff);
        r(ADDR_CONFIG, 32'h0000_8300);
        r(ADDR_PROTECT, 32'h0);
        r(ADDR_TIMER, 32'h0000_09c4);
        w(ADDR_CONFIG, 32'h1234_0000);
        r(ADDR_CONFIG, 32'h0000_8300);
        for (int k = 0; k < 4; k++) begin
            w(ADDR_CONFIG, {KEY_CONFIG, 5'h0, 3'(k), 8'h00});
            r(32'h0000_0400, 32'hffff_ffff);
            chk(32'(wcnt - w0), 32'(k + 1));
        end
        op(32'h4000_0200, 32'h0, 1'h0, SZ_WORD);
        chk(32'(st[1]), 32'h1);
        w(ADDR_CONFIG, {KEY_CONFIG, 16'h8000});
        op(32'h4000_0200, 32'h0, 1'h0, SZ_WORD);
        chk(32'(st[1]), 32'h0);
        w(ADDR_CONFIG, {KEY_CONFIG, 16'h00c0});
        r(32'h0, 32'hffff_ffff);
        r(ADDR_CRC, 32'h0000_ffff);
        w(ADDR_CONFIG, {KEY_CONFIG, 16'h0040});
        crc = 16'hffff;
        for (int k = 0; k < 3; k++) begin
            op(32'h2, 32'h0, 1'h0, 2'(k));
            chk(rd, 32'hffff_ffff);
            crc = crc_ones(crc, 8 << k);
        end
        r(ADDR_CRC, {16'h0, crc});
        w(ADDR_CONFIG, {KEY_CONFIG, 16'h0000});
        r(32'h0, 32'hffff_ffff);
        r(ADDR_CRC, {16'h0, crc});
        // init after folding must bring the value back
        w(ADDR_CONFIG, {KEY_CONFIG, 16'h00c0});
        r(ADDR_CRC, 32'h0000_ffff);
        w(ADDR_PROTECT, {KEY_PROT_HI, 16'hffff});
        r(ADDR_PROTECT, 32'h0000_fffc);
        w(ADDR_PROTECT, {KEY_PROT_LO, 16'h0003});
        r(ADDR_PROTECT, 32'h0000_ffff);
        w(ADDR_PROTECT, {16'h0055, 16'h0000});
        r(ADDR_PROTECT, 32'h0000_ffff);
        w(ADDR_PROTECT, {KEY_PROT_HI, 16'h0000});
        r(ADDR_PROTECT, 32'h0000_0003);
        w(ADDR_PROTECT, {KEY_PROT_LO, 16'h0002});
        r(ADDR_PROTECT, 32'h0000_0002);
        w(ADDR_DEBUG, {KEY_DEBUG, 16'h0000});
        chk(32'(debug_port_on), 32'h0);
        w(ADDR_DEBUG, {16'h1234, 16'h0001});
        chk(32'(debug_port_on), 32'h0);
        w(ADDR_DEBUG, {KEY_DEBUG, 16'h0001});
        chk(32'(debug_port_on), 32'h1);
        w(ADDR_TIMER, 32'h40);
        w(ADDR_ADDRESS, 32'h80);
        w(ADDR_CTRL, 32'h14);
        rb(MR_IDLE, 1'h1);
        w(ADDR_MODE, 32'h5a);
        w(ADDR_MODE, 32'ha5);
        rb(MR_FLASH, 1'h1);
        op(32'h0, 32'h0, 1'h0, SZ_WORD);
        chk(rd, 32'h0);
        chk(32'(st[1]), 32'h1);
        w(ADDR_CTRL, 32'h19);
        for (int k = 0; k < 2; k++) begin
            w(ADDR_ADDRESS, 32'h80 + 32'(4 * k));
            w(ADDR_DATA, 32'h1000_0000 + 32'(k));
        end
        w(ADDR_CTRL, 32'h08);
        w(ADDR_ADDRESS, 32'h88);
        w(ADDR_DATA, 32'h5555_5555);
        w(ADDR_ADDRESS, 32'h80);
        w(ADDR_CTRL, 32'h14);
        rb(MR_IDLE, 1'h0);
        idle();
        w(ADDR_ADDRESS, 32'h1000);
        w(ADDR_CTRL, 32'h14);
        rb(MR_IDLE, 1'h1);
        w(ADDR_MODE, 32'h0);
        r(32'h80, 32'h1000_0000);
        r(32'h84, 32'h1000_0001);
        r(32'h88, 32'hffff_ffff);
        r(32'h100, 32'hffff_ffff);
        r(32'h1000, 32'hffff_ffff);
        // ext pin stands still first: an erase timed from it must hang
        w(ADDR_CONFIG, {KEY_CONFIG, 16'h1000});
        w(ADDR_MODE, 32'h5a);
        w(ADDR_MODE, 32'ha5);
        w(ADDR_ADDRESS, 32'h80);
        w(ADDR_CTRL, 32'h12);
        repeat (100) @(posedge mclk);
        rb(MR_IDLE, 1'h0);
        repeat (160) begin
            repeat (2) @(posedge mclk);
            ext_clk_pin <= ~ext_clk_pin;
        end
        idle();
        w(ADDR_MODE, 32'h0);
        r(32'h80, 32'hffff_ffff);
        r(32'h84, 32'hffff_ffff);
        report_and_stop();
    end
endmodule // flash_memory_controller_tb

//--- fmc_crc16.sv
// fmc_crc16: one combinational crc16 step over 8, 16 or 32 data bits.
// assumes data sit in the low bits, the most significant data bit goes first.
`timescale 1ns/1ns
module fmc_crc16
    import fmc_pkg::*;
(
    // running value
    input wire logic [15:0] crc_in,
    // data and how many low bits count
    input wire logic [31:0] data,
    input wire logic [5:0] nbits,
    // result
    output logic [15:0] crc_out
);
    always_comb begin
        logic [15:0] c;
        logic fb;
        c = crc_in;
        fb = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (i < int'(nbits)) begin
                fb = c[15] ^ data[i];
                c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
            end
        end
        crc_out = c;
    end
endmodule // fmc_crc16

//--- fmc_device.sv
// fmc_device: flash controller end, array, page buffer, keyed protection.
// assumes the master holds a request until ack, then drops it.
`timescale 1ns/1ns
module fmc_device
    import fmc_pkg::*;
#(
    parameter int WORDS = FLASH_WORDS
) (
    // clock and control
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // link
    fmc_link_if.dev link,
    // pins
    input wire logic ext_clk_pin,
    output logic debug_port_on
);
    if (WORDS != FLASH_WORDS) begin : g_size_check
        $error("fmc_device: array size must match page organisation");
    end

    typedef enum {ST_IDLE, ST_WAIT, ST_DONE} fmc_dst_t;
    typedef struct packed {
        fmc_dst_t st;
        logic [2:0] wcnt;
        logic [15:0] cfg;
        logic [15:0] prot;
        logic dbg;
        logic [31:0] ar;
        logic [4:0] cr;
        logic [15:0] tmr;
        logic [15:0] tcnt;
        logic busy;
        logic op_pgm;
        logic flash_mode;
        logic entry;
        logic [15:0] crc;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic [2:0] ext_s;
    } fmc_dstate_t;

    fmc_dstate_t q, d;
    // erased flash reads as all ones
    logic [31:0] mem [WORDS] = '{default: 32'hffff_ffff};
    logic [31:0] pbuf [PAGE_WORDS];
    logic [31:0] rword;
    logic [31:0] lane;
    logic [5:0] nbits;
    logic [15:0] crc_next;
    logic take, is_flash, tick, done;
    logic buf_wr, buf_clr, do_pgm, do_ers;

    assign take = q.st == ST_IDLE && link.req;
    assign is_flash = link.addr < FLASH_LIMIT;
    assign rword = mem[link.addr[15:2]];
    // only the bytes the master asked for are folded into the crc
    always_comb begin
        unique case (link.size)
            SZ_BYTE: begin
                lane = rword >> {link.addr[1:0], 3'b000};
                nbits = 6'h08;
            end
            SZ_HALF: begin
                lane = rword >> {link.addr[1], 4'h0};
                nbits = 6'h10;
            end
            default: begin
                lane = rword;
                nbits = 6'h20;
            end
        endcase
    end
    fmc_crc16 u_crc (
        .crc_in(q.crc),
        .data(lane),
        .nbits(nbits),
        .crc_out(crc_next)
    );
    // internal source counts bus clocks; external counts synced rising edges
    assign tick = q.cfg[CFG_TMRSEL] ? (q.ext_s[1] & ~q.ext_s[2]) : 1'b1;
    assign done = q.busy && tick && q.tcnt == q.tmr;

    always_comb begin
        d = q;
        buf_wr = 1'b0;
        buf_clr = 1'b0;
        do_pgm = 1'b0;
        do_ers = 1'b0;
        d.ext_s = {q.ext_s[1:0], ext_clk_pin};
        d.ack = 1'b0;
        d.err = 1'b0;
        if (q.busy) begin
            if (tick)
                d.tcnt = q.tcnt + 16'h0001;
            if (done) begin
                d.busy = 1'b0;
                do_pgm = q.op_pgm;
                do_ers = ~q.op_pgm;
            end
        end
        if (q.cfg[CFG_INIT])
            d.crc = CRC_RESET;
        unique case (q.st)
            ST_IDLE: begin
                if (take) begin
                    if (!link.we && is_flash && !q.flash_mode && q.cfg[10:8] != 3'h0) begin
                        d.st = ST_WAIT;
                        d.wcnt = q.cfg[10:8] - 3'h1;
                    end else begin
                        d.st = ST_DONE;
                        d.ack = 1'b1;
                    end
                    if (!link.we) begin
                        d.rdata = 32'h0000_0000;
                        if (is_flash) begin
                            if (q.flash_mode) begin
                                d.err = ~q.cfg[CFG_ERRDIS];
                            end else begin
                                d.rdata = rword;
                                if (q.cfg[CFG_CRC_ON] && !q.cfg[CFG_INIT])
                                    d.crc = crc_next;
                            end
                        end else if (link.addr == ADDR_MODE) begin
                            d.rdata[MR_IDLE] = ~q.busy;
                            d.rdata[MR_FLASH] = q.flash_mode;
                        end else if (link.addr == ADDR_CTRL) begin
                            d.rdata[4:0] = q.cr;
                        end else if (link.addr == ADDR_ADDRESS) begin
                            d.rdata = q.ar;
                        end else if (link.addr == ADDR_TIMER) begin
                            d.rdata[15:0] = q.tmr;
                        end else if (link.addr == ADDR_CRC) begin
                            d.rdata[15:0] = q.crc;
                        end else if (link.addr == ADDR_CONFIG) begin
                            d.rdata[15:0] = q.cfg;
                        end else if (link.addr == ADDR_PROTECT) begin
                            d.rdata[15:0] = q.prot;
                        end else if (link.addr == ADDR_DEBUG) begin
                            d.rdata[0] = q.dbg;
                        end else if (link.addr != ADDR_DATA && link.addr != ADDR_BOOT) begin
                            d.err = ~q.cfg[CFG_ERRDIS];
                        end
                    end else begin
                        if (link.addr == ADDR_MODE) begin
                            d.entry = link.wdata[7:0] == CODE_ENTRY;
                            d.flash_mode = q.entry && link.wdata[7:0] == CODE_FLASH;
                        end else if (link.addr == ADDR_CTRL) begin
                            d.cr = link.wdata[4:0];
                            buf_clr = link.wdata[CR_PBR];
                            // a busy timer or normal mode ignores program and erase commands
                            if (q.flash_mode && !q.busy &&
                                (link.wdata[CR_PGM] || link.wdata[CR_ERASE]) &&
                                !q.prot[q.ar[15:12]]) begin
                                d.busy = 1'b1;
                                d.tcnt = 16'h0000;
                                d.op_pgm = link.wdata[CR_PGM];
                            end
                        end else if (link.addr == ADDR_ADDRESS) begin
                            d.ar = link.wdata;
                        end else if (link.addr == ADDR_DATA) begin
                            buf_wr = q.flash_mode && q.cr[CR_WE] && q.cr[CR_LOAD];
                        end else if (link.addr == ADDR_TIMER) begin
                            d.tmr = link.wdata[15:0];
                        end else if (link.addr == ADDR_CONFIG) begin
                            if (link.wdata[31:16] == KEY_CONFIG)
                                d.cfg = (q.cfg & ~CFG_WMASK) | (link.wdata[15:0] & CFG_WMASK);
                        end else if (link.addr == ADDR_PROTECT) begin
                            if (link.wdata[31:16] == KEY_PROT_HI)
                                d.prot[15:2] = link.wdata[15:2];
                            if (link.wdata[31:16] == KEY_PROT_LO)
                                d.prot[1:0] = link.wdata[1:0];
                        end else if (link.addr == ADDR_DEBUG) begin
                            if (link.wdata[31:16] == KEY_DEBUG)
                                d.dbg = link.wdata[0];
                        end else if (link.addr != ADDR_BOOT) begin
                            d.err = ~q.cfg[CFG_ERRDIS];
                        end
                    end
                    // read data wait for the answer, never move without ack
                    if (d.st == ST_WAIT)
                        d.rdata = q.rdata;
                end
            end
            ST_WAIT: begin
                if (q.wcnt == 3'h0) begin
                    d.st = ST_DONE;
                    d.ack = 1'b1;
                    d.rdata = rword;
                end else begin
                    d.wcnt = q.wcnt - 3'h1;
                end
            end
            ST_DONE: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q.st <= ST_IDLE;
            q.wcnt <= 3'h0;
            q.cfg <= CFG_RESET;
            q.prot <= 16'h0000;
            q.dbg <= DEBUG_RESET;
            q.ar <= 32'h0000_0000;
            q.cr <= 5'h00;
            q.tmr <= TMR_RESET;
            q.tcnt <= 16'h0000;
            q.busy <= 1'b0;
            q.op_pgm <= 1'b0;
            q.flash_mode <= 1'b0;
            q.entry <= 1'b0;
            q.crc <= CRC_RESET;
            q.ack <= 1'b0;
            q.err <= 1'b0;
            q.rdata <= 32'h0000_0000;
            q.ext_s <= 3'h0;
        end else if (ce) begin
            q <= d;
        end
    end

    // array and page buffer sit beside the state, too large for it
    always_ff @(posedge mclk) begin
        if (ce && !rst) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                if (buf_clr)
                    pbuf[i] <= 32'hffff_ffff;
                else if (buf_wr && q.ar[6:2] == i[4:0])
                    pbuf[i] <= link.wdata;
                if (do_pgm)
                    mem[{q.ar[15:7], i[4:0]}] <= pbuf[i];
                if (do_ers)
                    mem[{q.ar[15:7], i[4:0]}] <= 32'hffff_ffff;
            end
        end
    end

    assign link.ack = q.ack;
    assign link.err = q.err;
    assign link.rdata = q.rdata;
    assign debug_port_on = q.dbg;
endmodule // fmc_device

//--- fmc_host.sv
// fmc_host: bus master end, turns software commands into link transfers.
// assumes software waits for busy to fall before the next start.
`timescale 1ns/1ns
module fmc_host
    import fmc_pkg::*;
(
    // clock and control
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // software port
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    // link
    fmc_link_if.host link
);
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic req;
        logic we;
        logic [1:0] size;
        logic err;
        logic [31:0] rdata;
        logic [31:0] sw_rdata;
    } fmc_hstate_t;

    fmc_hstate_t q, d;

    always_comb begin
        d = q;
        d.sw_rdata = 32'h0000_0000;
        if (q.req && link.ack) begin
            d.req = 1'b0;
            d.err = link.err;
            if (!q.we)
                d.rdata = link.rdata;
        end
        if (sw_wr) begin
            if (sw_addr == H_ADDR)
                d.addr = sw_wdata;
            else if (sw_addr == H_WDATA)
                d.wdata = sw_wdata;
            else if (sw_addr == H_CMD && sw_wdata[0] && !q.req) begin
                d.req = 1'b1;
                d.we = sw_wdata[1];
                d.size = sw_wdata[3:2];
                d.err = 1'b0;
            end
        end
        if (sw_rd) begin
            if (sw_addr == H_ADDR)
                d.sw_rdata = q.addr;
            else if (sw_addr == H_WDATA)
                d.sw_rdata = q.wdata;
            else if (sw_addr == H_CMD)
                d.sw_rdata = {28'h0000000, q.size, q.we, 1'b0};
            else if (sw_addr == H_STATUS)
                d.sw_rdata = {30'h00000000, q.err, q.req};
            else if (sw_addr == H_RDATA)
                d.sw_rdata = q.rdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q.addr <= 32'h0000_0000;
            q.wdata <= 32'h0000_0000;
            q.req <= 1'b0;
            q.we <= 1'b0;
            q.size <= SZ_WORD;
            q.err <= 1'b0;
            q.rdata <= 32'h0000_0000;
            q.sw_rdata <= 32'h0000_0000;
        end else if (ce) begin
            q <= d;
        end
    end

    assign link.req = q.req;
    assign link.we = q.we;
    assign link.size = q.size;
    assign link.addr = q.addr;
    assign link.wdata = q.wdata;
    assign sw_rdata = q.sw_rdata;
endmodule // fmc_host

//--- fmc_link_if.sv
// fmc_link_if: request/answer link between bus master and flash controller.
// assumes one clock shared by both ends; the testbench joins them.
`timescale 1ns/1ns
interface fmc_link_if;
    import fmc_pkg::*;
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic ack;
    logic err;
    logic [31:0] rdata;
    modport dev (input req, input we, input size, input addr, input wdata,
        output ack, output err, output rdata);
    modport host (output req, output we, output size, output addr, output wdata,
        input ack, input err, input rdata);
endinterface

//--- fmc_link_properties.sv
// fmc_link_properties: link checks between bus master and flash controller.
// assumes one clock, sync reset high; shadows config and mode writes seen on the link.
`timescale 1ns/1ns
module fmc_link_properties
    import fmc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link
    input wire logic req,
    input wire logic we,
    input wire logic [1:0] size,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [7:0] cnt_q;
    logic [2:0] wait_q;
    logic errdis_q;
    logic mode_q;
    logic entry_q;
    logic wr_ack;
    logic flash_rd;
    assign wr_ack = ack && we;
    assign flash_rd = ack && !we && (addr < FLASH_LIMIT);
    // shadow state updates on the answer edge, before any next request
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            wait_q <= 3'h3;
            errdis_q <= 1'h1;
            mode_q <= 1'h0;
            entry_q <= 1'h0;
        end else begin
            cnt_q <= ack ? 8'h00 : cnt_q + 8'(req);
            if (wr_ack && addr == ADDR_CONFIG && wdata[31:16] == KEY_CONFIG) begin
                wait_q <= wdata[10:8];
                errdis_q <= wdata[CFG_ERRDIS];
            end
            if (wr_ack && addr == ADDR_MODE) begin
                entry_q <= wdata[7:0] == CODE_ENTRY;
                mode_q <= entry_q && wdata[7:0] == CODE_FLASH;
            end
        end
    end
    property p_flash_wait;
        flash_rd && !mode_q |-> cnt_q == 8'(wait_q) + 8'h01;
    endproperty
    a_flash_wait: assert property (p_flash_wait) else $error("flash read wait wrong");
    property p_reg_answer;
        ack && (we || addr >= FLASH_LIMIT) |-> cnt_q == 8'h01;
    endproperty
    a_reg_answer: assert property (p_reg_answer) else $error("register answer late");
    property p_mode_read;
        flash_rd && mode_q |-> rdata == 32'h0 && err == !errdis_q;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("array read in flash mode");
    property p_err_hidden;
        err |-> ack && !errdis_q;
    endproperty
    a_err_hidden: assert property (p_err_hidden) else $error("error not suppressed");
    property p_crc_width;
        ack && !we && addr == ADDR_CRC |-> rdata[31:16] == 16'h0;
    endproperty
    a_crc_width: assert property (p_crc_width) else $error("crc upper bits set");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_hold;
        req && !ack |=> req && $stable(addr) && $stable(we) && $stable(size);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before ack");
    property p_rdata_stands;
        !ack |-> $stable(rdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("rdata moved");
    property p_answer_bound;
        $rose(req) |-> ##[1:12] ack;
    endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("no answer");
    property p_flash_flag;
        ack && !we && addr == ADDR_MODE |-> rdata[MR_FLASH] == mode_q;
    endproperty
    a_flash_flag: assert property (p_flash_flag) else $error("flash mode flag wrong");
endmodule // fmc_link_properties

//--- fmc_pkg.sv
// fmc_pkg: shared constants for the flash controller and its bus master.
// assumes both ends and the interface import it whole.
package fmc_pkg;
    // link address map
    localparam logic [31:0] FLASH_LIMIT = 32'h0001_0000;
    localparam logic [31:0] ADDR_MODE = 32'h4000_0104;
    localparam logic [31:0] ADDR_CTRL = 32'h4000_0108;
    localparam logic [31:0] ADDR_ADDRESS = 32'h4000_010c;
    localparam logic [31:0] ADDR_DATA = 32'h4000_0110;
    localparam logic [31:0] ADDR_TIMER = 32'h4000_0114;
    localparam logic [31:0] ADDR_CRC = 32'h4000_0120;
    localparam logic [31:0] ADDR_CONFIG = 32'h4000_0130;
    localparam logic [31:0] ADDR_BOOT = 32'h4000_0174;
    localparam logic [31:0] ADDR_PROTECT = 32'h4000_0178;
    localparam logic [31:0] ADDR_DEBUG = 32'h4000_017c;
    // keys
    localparam logic [15:0] KEY_CONFIG = 16'h7858;
    localparam logic [15:0] KEY_PROT_HI = 16'h0087;
    localparam logic [15:0] KEY_PROT_LO = 16'h0098;
    localparam logic [15:0] KEY_DEBUG = 16'h00c7;
    localparam logic [7:0] CODE_ENTRY = 8'h5a;
    localparam logic [7:0] CODE_FLASH = 8'ha5;
    // config fields
    localparam int CFG_ERRDIS = 15;
    localparam int CFG_TMRSEL = 12;
    localparam int CFG_WAIT_LSB = 8;
    localparam int CFG_INIT = 7;
    localparam int CFG_CRC_ON = 6;
    localparam logic [15:0] CFG_RESET = 16'h8300;
    // wait field 10:8 is writable as a whole
    localparam logic [15:0] CFG_WMASK = 16'h97cf;
    // control fields
    localparam int CR_WE = 4;
    localparam int CR_LOAD = 3;
    localparam int CR_PGM = 2;
    localparam int CR_ERASE = 1;
    localparam int CR_PBR = 0;
    // mode register fields
    localparam int MR_IDLE = 24;
    localparam int MR_FLASH = 8;
    // reset values and crc polynomial
    localparam logic [15:0] CRC_RESET = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] TMR_RESET = 16'h09c4;
    localparam logic DEBUG_RESET = 1'b1;
    // organisation
    localparam int PAGES = 1024;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_WORDS = PAGE_BYTES / 4;
    localparam int FLASH_WORDS = PAGES * PAGE_WORDS;
    // access size on the link
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    // host command port map
    localparam logic [7:0] H_ADDR = 8'h00;
    localparam logic [7:0] H_WDATA = 8'h04;
    localparam logic [7:0] H_CMD = 8'h08;
    localparam logic [7:0] H_STATUS = 8'h0c;
    localparam logic [7:0] H_RDATA = 8'h10;
endpackage
